//--- core/asp_pkg.sv
// constants shared by the async sram port controller
package asp_pkg;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // power-up settle time in microseconds
    localparam int unsigned POWERUP_US    = 1000;
    localparam int unsigned POWERUP_CYC   = (POWERUP_US * 1000) / CLK_PERIOD_NS;
    // slowest grade cycle time, ns
    localparam int unsigned CYCLE_NS      = 12;
    localparam int unsigned PHASE_CYC_MIN = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 17;
    localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 17'h00001;
    typedef enum logic [4:0] {
        ASP_POWERUP = 5'h01,
        ASP_IDLE    = 5'h02,
        ASP_READ    = 5'h04,
        ASP_WRITE   = 5'h08,
        ASP_RECOVER = 5'h10
    } asp_state_e;
endpackage

//--- core/asp_timer.sv
// down counter that flags when a loaded cycle count has expired
module asp_timer (
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    load_i,
    input  wire logic [asp_pkg::CNT_W-1:0] count_i,
    output logic                         done_o
);
    logic [asp_pkg::CNT_W-1:0] cnt_r;

    // load wins over counting so a new phase always starts full length
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= asp_pkg::CNT_ZERO;
        end else if (load_i) begin
            cnt_r <= count_i;
        end else if (cnt_r != asp_pkg::CNT_ZERO) begin
            cnt_r <= cnt_r - asp_pkg::CNT_ONE;
        end
    end

    assign done_o = (cnt_r == asp_pkg::CNT_ZERO);
endmodule

//--- core/asp_ctrl.sv
// host-side controller driving an asynchronous 1M x 16 sram
// Functional notes
// RULE1 - memory holds 1M words of 16 bits
// RULE2 - 20-bit address selects the word
// RULE3 - write: select low, write strobe low
// RULE4 - low byte select gates lower byte write
// RULE5 - high byte select gates upper byte write
// RULE6 - read: select, output drive low, strobe high
// RULE7 - memory drives low byte when selected
// RULE8 - memory drives high byte when selected
// RULE9 - memory floats when deselected or disabled
// RULE10 - memory never drives during a write
// RULE11 - memory enters standby when deselected
// RULE12 - wait power-up interval before any access
// RULE13 - no valid operation before supply ready
// RULE14 - read data valid within access time
// RULE15 - write ends at first rising control
// RULE16 - phase lengths from clock-count parameter
module asp_ctrl #(
    parameter int unsigned POWERUP_CYCLES = asp_pkg::POWERUP_CYC,
    parameter int unsigned PHASE_CYCLES   = asp_pkg::PHASE_CYC_MIN
) (
    input  wire logic                     CLK_I,
    input  wire logic                     ARST_N_I,
    // user request side
    input  wire logic                     REQ_VALID_I,
    input  wire logic                     REQ_WRITE_I,
    input  wire logic [asp_pkg::ADDR_W-1:0] REQ_ADDR_I,
    input  wire logic [asp_pkg::DATA_W-1:0] REQ_WDATA_I,
    input  wire logic [1:0]               REQ_BYTE_EN_I,
    output logic                          REQ_READY_O,
    output logic                          RSP_VALID_O,
    output logic [asp_pkg::DATA_W-1:0]    RSP_RDATA_O,
    output logic                          POWER_OK_O,
    // sram pins
    output logic [asp_pkg::ADDR_W-1:0]    MEM_ADDR_O,
    output logic                          MEM_CHIP_SELECT_N_O,
    output logic                          MEM_WRITE_STROBE_N_O,
    output logic                          MEM_OUTPUT_DRIVE_N_O,
    output logic                          MEM_LOW_BYTE_SEL_N_O,
    output logic                          MEM_HIGH_BYTE_SEL_N_O,
    input  wire logic [asp_pkg::DATA_W-1:0] MEM_DATA_I,
    output logic [asp_pkg::DATA_W-1:0]    MEM_DATA_O,
    output logic                          MEM_DATA_OE_N_O
);
    localparam logic [asp_pkg::CNT_W-1:0] PWR_LOAD = asp_pkg::CNT_W'(POWERUP_CYCLES);
    localparam logic [asp_pkg::CNT_W-1:0] PH_LOAD  = asp_pkg::CNT_W'(PHASE_CYCLES - 1);

    asp_pkg::asp_state_e                 state_r;
    asp_pkg::asp_state_e                 state_nxt;
    logic                                timer_load;
    logic [asp_pkg::CNT_W-1:0]           timer_count;
    logic                                timer_done;
    logic                                pwr_started_r;
    logic [asp_pkg::DATA_W-1:0]          din_meta_r;
    logic [asp_pkg::DATA_W-1:0]          din_sync_r;
    logic                                accept;
    logic [1:0]                          rd_pipe_r;

    // phase timer shared by power-up wait and access phases
    asp_timer u_timer (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .load_i   (timer_load),
        .count_i  (timer_count),
        .done_o   (timer_done)
    );

    assign accept = (state_r == asp_pkg::ASP_IDLE) && REQ_VALID_I;

    // next state: no access until power-up wait has run out
    always_comb begin
        state_nxt   = state_r;
        timer_load  = 1'b0;
        timer_count = PH_LOAD;
        case (state_r)
            asp_pkg::ASP_POWERUP: begin
                if (!pwr_started_r) begin
                    timer_load  = 1'b1; // RULE12
                    timer_count = PWR_LOAD;
                end else if (timer_done) begin
                    state_nxt = asp_pkg::ASP_IDLE; // RULE12
                end
            end
            asp_pkg::ASP_IDLE: begin
                if (REQ_VALID_I) begin
                    timer_load = 1'b1; // RULE16
                    state_nxt  = REQ_WRITE_I ? asp_pkg::ASP_WRITE : asp_pkg::ASP_READ;
                end
            end
            asp_pkg::ASP_READ: begin
                if (timer_done) begin
                    timer_load = 1'b1;
                    state_nxt  = asp_pkg::ASP_RECOVER;
                end
            end
            asp_pkg::ASP_WRITE: begin
                if (timer_done) begin
                    timer_load = 1'b1;
                    state_nxt  = asp_pkg::ASP_RECOVER;
                end
            end
            asp_pkg::ASP_RECOVER: begin
                if (timer_done) begin
                    state_nxt = asp_pkg::ASP_IDLE;
                end
            end
            default: begin
                state_nxt = asp_pkg::ASP_POWERUP;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= asp_pkg::ASP_POWERUP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // marks that the power-up count was loaded once
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pwr_started_r <= 1'b0;
        end else begin
            pwr_started_r <= 1'b1;
        end
    end

    // power-good flag; supply level itself is outside this logic
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            POWER_OK_O <= 1'b0;
        end else begin
            POWER_OK_O <= (state_nxt != asp_pkg::ASP_POWERUP); // RULE13
        end
    end

    // ready only in idle once the next cycle stays idle
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            REQ_READY_O <= 1'b0;
        end else begin
            REQ_READY_O <= (state_nxt == asp_pkg::ASP_IDLE);
        end
    end

    // address and write data held for the whole access and recovery
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MEM_ADDR_O            <= '0;
            MEM_DATA_O            <= '0;
            MEM_LOW_BYTE_SEL_N_O  <= 1'b1;
            MEM_HIGH_BYTE_SEL_N_O <= 1'b1;
        end else if (accept && REQ_READY_O) begin
            MEM_ADDR_O            <= REQ_ADDR_I; // RULE2
            MEM_DATA_O            <= REQ_WDATA_I;
            MEM_LOW_BYTE_SEL_N_O  <= ~REQ_BYTE_EN_I[0]; // RULE4 RULE7
            MEM_HIGH_BYTE_SEL_N_O <= ~REQ_BYTE_EN_I[1]; // RULE5 RULE8
        end
    end

    // control strobes; select and strobe fall together so the
    // write ends when both rise at the same edge, with address held
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MEM_CHIP_SELECT_N_O  <= 1'b1;
            MEM_WRITE_STROBE_N_O <= 1'b1;
            MEM_OUTPUT_DRIVE_N_O <= 1'b1;
        end else begin
            MEM_CHIP_SELECT_N_O  <= !((state_nxt == asp_pkg::ASP_READ) ||
                                      (state_nxt == asp_pkg::ASP_WRITE)); // RULE3 RULE6
            MEM_WRITE_STROBE_N_O <= (state_nxt != asp_pkg::ASP_WRITE); // RULE3 RULE15
            MEM_OUTPUT_DRIVE_N_O <= (state_nxt != asp_pkg::ASP_READ); // RULE6
        end
    end

    // host drives the bus while writing and one cycle past the strobe rise,
    // so data hold is met; memory is deselected then, so no fight
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MEM_DATA_OE_N_O <= 1'b1;
        end else begin
            MEM_DATA_OE_N_O <= !((state_nxt == asp_pkg::ASP_WRITE) ||
                                 (state_r == asp_pkg::ASP_WRITE)); // RULE10 RULE15
        end
    end

    // read data from pins crosses two flops before use
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            din_meta_r <= '0;
            din_sync_r <= '0;
        end else begin
            din_meta_r <= MEM_DATA_I;
            din_sync_r <= din_meta_r;
        end
    end

    // read end marker follows the bus through both sync flops
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rd_pipe_r <= 2'h0;
        end else begin
            rd_pipe_r <= {rd_pipe_r[0], (state_r == asp_pkg::ASP_READ) && timer_done};
        end
    end

    // bus sampled on the edge that ends the read phase, so the whole
    // phase counts toward access time; costs two cycles of latency
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_RDATA_O <= '0;
        end else begin
            RSP_VALID_O <= 1'b0;
            if (rd_pipe_r[1]) begin
                RSP_VALID_O <= 1'b1; // RULE14
                RSP_RDATA_O <= din_sync_r;
            end
        end
    end
endmodule

//--- testbench/asp_sram_model.sv
// behavioural 1m x 16 asynchronous sram for the controller bench
module asp_sram_model (
    input  wire logic [19:0] addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        lb_n_i,
    input  wire logic        hb_n_i,
    input  wire logic [15:0] bus_i,
    output logic      [15:0] q_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:1048575];
    logic [15:0] rd;
    logic        drv;
    logic        standby;
    // supply taken as good from time zero, so no gating here
    assign standby = cs_n_i;
    // store while select and strobe overlap; first control to rise ends it
    always @(cs_n_i, we_n_i, lb_n_i, hb_n_i, addr_i, bus_i)
        if (!cs_n_i && !we_n_i) begin
            if (!lb_n_i) mem[addr_i][7:0] = bus_i[7:0];
            if (!hb_n_i) mem[addr_i][15:8] = bus_i[15:8];
        end
    // never drives during a write; a floating lane shows a wrong value
    assign drv = !standby && !oe_n_i && we_n_i && !(lb_n_i && hb_n_i);
    assign rd = mem[addr_i];
    assign #8 q_o = {drv && !hb_n_i ? rd[15:8] : ~rd[15:8],
                     drv && !lb_n_i ? rd[7:0] : ~rd[7:0]};
endmodule

//--- testbench/asp_ctrl_checker.sv
// port-level assertions for the async sram controller
module asp_ctrl_checker #(
    parameter int unsigned PHASE_CYCLES = 2
) (
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        REQ_VALID_I,
    input  wire logic        REQ_WRITE_I,
    input  wire logic [19:0] REQ_ADDR_I,
    input  wire logic [15:0] REQ_WDATA_I,
    input  wire logic [1:0]  REQ_BYTE_EN_I,
    input  wire logic        REQ_READY_O,
    input  wire logic        RSP_VALID_O,
    input  wire logic        POWER_OK_O,
    input  wire logic [19:0] MEM_ADDR_O,
    input  wire logic        MEM_CHIP_SELECT_N_O,
    input  wire logic        MEM_WRITE_STROBE_N_O,
    input  wire logic        MEM_OUTPUT_DRIVE_N_O,
    input  wire logic        MEM_LOW_BYTE_SEL_N_O,
    input  wire logic        MEM_HIGH_BYTE_SEL_N_O,
    input  wire logic [15:0] MEM_DATA_O,
    input  wire logic        MEM_DATA_OE_N_O
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD_LAT = PHASE_CYCLES + 3;
    localparam int WR_LAT = 2 * PHASE_CYCLES + 1;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // accepted requests of each kind
    sequence rd_take; REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I; endsequence
    sequence wr_take; REQ_VALID_I && REQ_READY_O && REQ_WRITE_I; endsequence
    read_start_a: assert property (rd_take |=> !MEM_CHIP_SELECT_N_O && !MEM_OUTPUT_DRIVE_N_O
        && MEM_WRITE_STROBE_N_O && !REQ_READY_O) else $error("read strobes wrong");
    read_end_a: assert property (rd_take |-> ##RD_LAT RSP_VALID_O && MEM_CHIP_SELECT_N_O)
        else $error("read answer late");
    write_start_a: assert property (wr_take |=> !MEM_CHIP_SELECT_N_O && !MEM_WRITE_STROBE_N_O
        && !MEM_DATA_OE_N_O && MEM_DATA_O == $past(REQ_WDATA_I)) else $error("write start wrong");
    lane_select_a: assert property ((rd_take or wr_take) |=> MEM_ADDR_O == $past(REQ_ADDR_I)
        && {MEM_HIGH_BYTE_SEL_N_O, MEM_LOW_BYTE_SEL_N_O} == ~$past(REQ_BYTE_EN_I))
        else $error("address or lanes wrong");
    bus_release_a: assert property (!MEM_CHIP_SELECT_N_O && !MEM_OUTPUT_DRIVE_N_O
        |-> MEM_DATA_OE_N_O) else $error("bus driven during read");
    write_end_a: assert property ($rose(MEM_WRITE_STROBE_N_O) |-> $rose(MEM_CHIP_SELECT_N_O))
        else $error("write end split");
    power_wait_a: assert property (!POWER_OK_O |-> MEM_CHIP_SELECT_N_O && !REQ_READY_O)
        else $error("access before power-up");
    ready_back_a: assert property (wr_take |-> ##WR_LAT REQ_READY_O)
        else $error("ready not back");
endmodule
bind asp_ctrl asp_ctrl_checker #(.PHASE_CYCLES(PHASE_CYCLES)) u_chk (
    .CLK_I                 (CLK_I),
    .ARST_N_I              (ARST_N_I),
    .REQ_VALID_I           (REQ_VALID_I),
    .REQ_WRITE_I           (REQ_WRITE_I),
    .REQ_ADDR_I            (REQ_ADDR_I),
    .REQ_WDATA_I           (REQ_WDATA_I),
    .REQ_BYTE_EN_I         (REQ_BYTE_EN_I),
    .REQ_READY_O           (REQ_READY_O),
    .RSP_VALID_O           (RSP_VALID_O),
    .POWER_OK_O            (POWER_OK_O),
    .MEM_ADDR_O            (MEM_ADDR_O),
    .MEM_CHIP_SELECT_N_O   (MEM_CHIP_SELECT_N_O),
    .MEM_WRITE_STROBE_N_O  (MEM_WRITE_STROBE_N_O),
    .MEM_OUTPUT_DRIVE_N_O  (MEM_OUTPUT_DRIVE_N_O),
    .MEM_LOW_BYTE_SEL_N_O  (MEM_LOW_BYTE_SEL_N_O),
    .MEM_HIGH_BYTE_SEL_N_O (MEM_HIGH_BYTE_SEL_N_O),
    .MEM_DATA_O            (MEM_DATA_O),
    .MEM_DATA_OE_N_O       (MEM_DATA_OE_N_O)
);

//--- testbench/test_asp_ctrl.sv
// self-checking bench for the async sram port controller
module test_asp_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        wr;
        logic [19:0] a;
        logic [15:0] d;
        logic [1:0]  be;
        logic [15:0] m;
    } asp_row_s;
    logic        clk, rst_n, valid, write, rdy, rsp, pok, cs_n, we_n, oe_n, lb_n, hb_n, doe_n;
    logic [19:0] addr, maddr;
    logic [15:0] wd, rdata, mdo, mq, bus;
    logic [1:0]  be;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // read rows hold the expected word under the lane mask
    asp_row_s rows [11] = '{
        '{1'b1, 20'h00001, 16'h1234, 2'h3, 16'hffff},
        '{1'b1, 20'hfffff, 16'habcd, 2'h3, 16'hffff},
        '{1'b0, 20'h00001, 16'h1234, 2'h3, 16'hffff},
        '{1'b0, 20'hfffff, 16'habcd, 2'h3, 16'hffff},
        '{1'b1, 20'h00001, 16'hff56, 2'h1, 16'hffff},
        '{1'b1, 20'hfffff, 16'h99ff, 2'h2, 16'hffff},
        '{1'b1, 20'h00001, 16'h0000, 2'h0, 16'hffff},
        '{1'b0, 20'h00001, 16'h1256, 2'h3, 16'hffff},
        '{1'b0, 20'hfffff, 16'h99cd, 2'h3, 16'hffff},
        '{1'b0, 20'hfffff, 16'h00cd, 2'h1, 16'h00ff},
        '{1'b0, 20'h00001, 16'h1200, 2'h2, 16'hff00}
    };
    assign bus = doe_n ? mq : mdo;
    asp_ctrl #(.POWERUP_CYCLES(8), .PHASE_CYCLES(2)) dut (
        .CLK_I(clk), .ARST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(write),
        .REQ_ADDR_I(addr), .REQ_WDATA_I(wd), .REQ_BYTE_EN_I(be), .REQ_READY_O(rdy),
        .RSP_VALID_O(rsp), .RSP_RDATA_O(rdata), .POWER_OK_O(pok), .MEM_ADDR_O(maddr),
        .MEM_CHIP_SELECT_N_O(cs_n), .MEM_WRITE_STROBE_N_O(we_n), .MEM_OUTPUT_DRIVE_N_O(oe_n),
        .MEM_LOW_BYTE_SEL_N_O(lb_n), .MEM_HIGH_BYTE_SEL_N_O(hb_n), .MEM_DATA_I(bus),
        .MEM_DATA_O(mdo), .MEM_DATA_OE_N_O(doe_n));
    asp_sram_model u_mem (.addr_i(maddr), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .lb_n_i(lb_n), .hb_n_i(hb_n), .bus_i(bus), .q_o(mq));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // request held until seen ready at a falling edge, so the next rise takes it
    task automatic acc(input asp_row_s r);
        @(negedge clk);
        {valid, write, addr, wd, be} = {1'b1, r.wr, r.a, r.d, r.be};
        while (rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        valid = 0;
        if (!r.wr) begin
            while (rsp !== 1'b1) @(negedge clk);
            chk({4'h0, rdata & r.m}, {4'h0, r.d});
        end
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // ceiling far above the roughly 95 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        {rst_n, valid, write, addr, wd, be} = '0;
        repeat (2) @(negedge clk);
        chk({15'h0000, pok, rdy, cs_n, we_n, doe_n}, 20'h00007);
        rst_n = 1;
        foreach (rows[i]) acc(rows[i]);
        // second reset in mid-write: strobes must rise at once
        @(negedge clk);
        {valid, write, addr, wd, be} = {1'b1, 1'b1, 20'h00002, 16'hbeef, 2'h3};
        while (cs_n !== 1'b0) @(negedge clk);
        rst_n = 0;
        #1 chk({17'h00000, cs_n, we_n, doe_n}, 20'h00007);
        @(negedge clk);
        rst_n = 1;
        // held request stays refused until the power-up wait ends
        repeat (5) @(negedge clk);
        chk({18'h00000, pok, cs_n}, 20'h00001);
        acc('{1'b1, 20'h00002, 16'hbeef, 2'h3, 16'hffff});
        acc('{1'b0, 20'h00002, 16'hbeef, 2'h3, 16'hffff});
        test_done;
    end
endmodule
